// >>> src/eep_regs.svh
// Constants for the two-wire serial EEPROM slave
`ifndef EEP_REGS_SVH
`define EEP_REGS_SVH
`define EEP_DEV_TYPE 4'ha
`define EEP_ADDR_W 13
`define EEP_PAGE_W 5
`define EEP_CLK_MHZ 20
`define EEP_WR_TIME_US 5000
`define EEP_WR_CYCLES (`EEP_WR_TIME_US * `EEP_CLK_MHZ)
`endif

// >>> src/eep_pkg.sv
// State types for the two-wire serial EEPROM slave
package eep_pkg;
   typedef enum logic [2:0] {L_IDLE, L_DEV, L_ADRH, L_ADRL, L_WDATA, L_RDATA} eep_link_st_type;
   typedef enum logic [1:0] {S_IDLE, S_COPY, S_WAIT} eep_sys_st_type;
endpackage

// >>> src/eep_sync_if.sv
// Level bundle carried into a two-flop synchroniser
`timescale 1ns/1ns
interface eep_sync_if #(parameter int W = 1);
   logic [W-1:0] async_lvl;
   logic [W-1:0] sync_lvl;
   modport src (output async_lvl, input sync_lvl);
   modport dst (input async_lvl, output sync_lvl);
endinterface

// >>> src/eep_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ns
module eep_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic rst_in,
   eep_sync_if.dst port
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } eep_sync_reg_type;

   eep_sync_reg_type r_q;
   eep_sync_reg_type r_d;

   if (W < 1 || W != $bits(port.async_lvl)) begin : g_bad_w
      $error("eep_sync width mismatch");
   end

   always_comb begin
      r_d.s1 = port.async_lvl;
      r_d.s2 = r_q.s1;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign port.sync_lvl = r_q.s2;
endmodule // eep_sync

// >>> src/eep_slave.sv
// Two-wire serial EEPROM slave: protocol, address counter, page buffer, array
`timescale 1ns/1ns
`include "eep_regs.svh"
// Contract
// R1: Each access starts after a start with an eight-bit device address word.
// R2: Upper four device address bits must match the fixed family pattern.
// R3: That fixed upper nibble is binary 1010, sent most significant bit first.
// R4: Next three bits must equal the three chip-select pin levels.
// R5: Eighth device address bit: one means read, zero means write.
// R6: Match acknowledges by pulling data low; mismatch returns to standby, line released.
// R7: Write acknowledges the word address, then receives and acknowledges a data byte.
// R8: Word address comes as two bytes, high first; unused upper bits ignored.
// R9: Stop after acknowledged write data starts the timed internal write cycle.
// R10: During the internal write cycle inputs are ignored and nothing is acknowledged.
// R11: Page write: up to thirty-one further bytes, each acknowledged, ended by stop.
// R12: Each write byte increments only the low five word address bits.
// R13: Passing the page boundary wraps to the page start, overwriting earlier bytes.
// R14: Polling with start and device address acknowledges only after write completes.
// R15: Address counter holds last accessed address plus one between operations.
// R16: Read increment past the last byte wraps to the first byte.
// R17: After acknowledging a read address word, shift out the byte at the counter.
// R18: Master ends a single read with no acknowledge and a stop.
// R19: Random read is a dummy write of address then repeated start and read.
// R20: Each master acknowledge of a read byte advances and sends the next byte.
// R21: Missing master acknowledge ends a sequential read; the device releases data.
// R22: Device acknowledge is driven low during the ninth clock of each word.
// R23: Word address is twelve or thirteen bits depending on density.
// R24: Data falling with clock high is start; data rising with clock high is stop.
// R25: Array is 128 or 256 pages of 32 bytes; page wrap follows that size.
module eep_slave #(
   parameter int ADDR_W = `EEP_ADDR_W,
   parameter int PAGE_W = `EEP_PAGE_W,
   parameter int WR_CYCLES = `EEP_WR_CYCLES
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic chip_select_bit_2_in,
   input wire logic chip_select_bit_1_in,
   input wire logic chip_select_bit_0_in,
   output logic sda_out,
   output logic sda_oe_out,
   output logic write_busy_out
);
   localparam int PAGE_BYTES = 1 << PAGE_W;
   localparam int MEM_BYTES = 1 << ADDR_W;
   // Copy runs one cycle per page byte; the wait state shows one cycle after the last index
   localparam int COPY_TAIL = PAGE_BYTES - 7;

   // Pages under eight bytes would leave the copy check with a negative delay
   if (ADDR_W < 9 || ADDR_W > 16 || PAGE_W < 3 || PAGE_W > 8 || WR_CYCLES < 1) begin : g_bad
      $error("eep_slave parameters out of range");
   end

   typedef struct packed {
      eep_pkg::eep_link_st_type st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic drive;
      logic start_ack;
      logic wr_first;
      logic wr_seq;
      logic [ADDR_W-1:0] addr;
      logic [PAGE_BYTES-1:0][7:0] pbuf;
      logic [PAGE_BYTES-1:0] pval;
   } eep_link_reg_type;

   typedef struct packed {
      eep_pkg::eep_sys_st_type st;
      logic [PAGE_W-1:0] idx;
      logic [31:0] wcnt;
      logic seq_done;
      logic scl_p;
      logic sda_p;
   } eep_sys_reg_type;

   eep_link_reg_type ls_q;
   eep_link_reg_type ls_d;
   eep_sys_reg_type ss_q;
   eep_sys_reg_type ss_d;

   // Array contents; no reset, like the real cells
   logic [7:0] mem [0:MEM_BYTES-1];

   logic start_tgl_q;
   logic rise_q;
   logic start_seen;
   logic [7:0] byte_w;
   logic [7:0] rd_byte;
   logic dev_match;
   logic busy_l;
   logic [2:0] cs_l;
   logic stop_det;
   logic mem_we;
   logic [ADDR_W-1:0] mem_wa;

   eep_sync_if #(.W(3)) sys_pins ();
   eep_sync_if #(.W(4)) link_lvls ();

   assign sys_pins.async_lvl = {ls_q.wr_seq, sda_in, scl_in};
   assign link_lvls.async_lvl = {write_busy_out, chip_select_bit_2_in,
                                 chip_select_bit_1_in, chip_select_bit_0_in};
   assign busy_l = link_lvls.sync_lvl[3];
   assign cs_l = link_lvls.sync_lvl[2:0];

   eep_sync #(.W(3)) u_sys_sync (
      .clk_in(clk_sys_in),
      .rst_in(rst_in),
      .port(sys_pins)
   );

   // Straps and busy are levels; scl edges over the address byte settle them
   eep_sync #(.W(4)) u_link_sync (
      .clk_in(scl_in),
      .rst_in(rst_in),
      .port(link_lvls)
   );

   // Start is the only data edge with clock high that matters here; a toggle
   // keeps it single-driver and the link side compares it on its next fall
   always_ff @(negedge sda_in or posedge rst_in) begin
      if (rst_in) begin
         start_tgl_q <= 1'b0;
      end else if (scl_in) begin
         start_tgl_q <= ~start_tgl_q; // R24
      end
   end

   always_ff @(posedge scl_in or posedge rst_in) begin
      if (rst_in) begin
         rise_q <= 1'b1;
      end else begin
         rise_q <= sda_in;
      end
   end

   assign rd_byte = mem[ls_q.addr];

   // Link side: runs on falling clock, so the line only moves while clock is low
   always_comb begin
      ls_d = ls_q;
      start_seen = start_tgl_q != ls_q.start_ack;
      byte_w = {ls_q.sh[6:0], rise_q};
      dev_match = (byte_w[7:4] == `EEP_DEV_TYPE) && (byte_w[3:1] == cs_l); // R2 R3 R4
      ls_d.start_ack = start_tgl_q;
      ls_d.cnt = ls_q.cnt + 4'h1;
      if (start_seen) begin
         ls_d.st = eep_pkg::L_DEV; // R1
         ls_d.cnt = 4'h0;
         ls_d.drive = 1'b0;
      end else begin
         unique case (ls_q.st)
            eep_pkg::L_IDLE: begin
               ls_d.cnt = 4'h0;
               ls_d.drive = 1'b0;
            end
            eep_pkg::L_RDATA: begin
               if (ls_q.cnt < 4'h7) begin
                  ls_d.sh = {ls_q.sh[6:0], 1'b0};
                  ls_d.drive = ~ls_q.sh[6];
               end else if (ls_q.cnt == 4'h7) begin
                  ls_d.drive = 1'b0;
                  ls_d.addr = ls_q.addr + 1'b1; // R15 R16
               end else if (!rise_q) begin
                  ls_d.cnt = 4'h0; // R20
                  ls_d.sh = rd_byte;
                  ls_d.drive = ~rd_byte[7];
               end else begin
                  ls_d.st = eep_pkg::L_IDLE; // R21
               end
            end
            eep_pkg::L_DEV, eep_pkg::L_ADRH, eep_pkg::L_ADRL, eep_pkg::L_WDATA: begin
               if (ls_q.cnt != 4'h8) begin
                  ls_d.sh = byte_w;
               end
               if (ls_q.cnt == 4'h7) begin
                  ls_d.drive = 1'b1; // R22
                  unique case (ls_q.st)
                     eep_pkg::L_DEV: begin
                        if (dev_match && !busy_l) begin // R10 R14
                           ls_d.rw = byte_w[0]; // R5
                           if (!byte_w[0]) begin
                              ls_d.pval = '0;
                              ls_d.wr_first = 1'b1;
                           end
                        end else begin
                           ls_d.drive = 1'b0; // R6
                           ls_d.st = eep_pkg::L_IDLE;
                        end
                     end
                     eep_pkg::L_ADRH: begin
                        ls_d.addr[ADDR_W-1:8] = byte_w[ADDR_W-9:0]; // R8 R23
                     end
                     eep_pkg::L_ADRL: begin
                        ls_d.addr[7:0] = byte_w; // R7
                     end
                     eep_pkg::L_WDATA: begin
                        ls_d.pbuf[ls_q.addr[PAGE_W-1:0]] = byte_w; // R11
                        ls_d.pval[ls_q.addr[PAGE_W-1:0]] = 1'b1;
                        ls_d.addr[PAGE_W-1:0] = ls_q.addr[PAGE_W-1:0] + 1'b1; // R12 R13 R25
                        if (ls_q.wr_first) begin
                           ls_d.wr_first = 1'b0;
                           ls_d.wr_seq = ~ls_q.wr_seq;
                        end
                     end
                     eep_pkg::L_IDLE, eep_pkg::L_RDATA: begin
                     end
                  endcase
               end
               if (ls_q.cnt == 4'h8) begin
                  ls_d.drive = 1'b0;
                  ls_d.cnt = 4'h0;
                  unique case (ls_q.st)
                     eep_pkg::L_DEV: begin
                        if (ls_q.rw) begin
                           ls_d.st = eep_pkg::L_RDATA; // R17
                           ls_d.sh = rd_byte;
                           ls_d.drive = ~rd_byte[7];
                        end else begin
                           ls_d.st = eep_pkg::L_ADRH;
                        end
                     end
                     eep_pkg::L_ADRH: ls_d.st = eep_pkg::L_ADRL;
                     eep_pkg::L_ADRL: ls_d.st = eep_pkg::L_WDATA;
                     eep_pkg::L_WDATA, eep_pkg::L_IDLE, eep_pkg::L_RDATA: begin
                     end
                  endcase
               end
            end
         endcase
      end
   end

   always_ff @(negedge scl_in or posedge rst_in) begin
      if (rst_in) begin
         ls_q <= '0;
      end else begin
         ls_q <= ls_d;
      end
   end

   // System side: stop detection, page commit and the timed write.
   // Page buffer and address are read across domains without a handshake:
   // they only change after an acknowledged address, which busy prevents.
   always_comb begin
      ss_d = ss_q;
      ss_d.scl_p = sys_pins.sync_lvl[0];
      ss_d.sda_p = sys_pins.sync_lvl[1];
      stop_det = sys_pins.sync_lvl[0] && ss_q.scl_p && sys_pins.sync_lvl[1] && !ss_q.sda_p;
      mem_we = 1'b0;
      mem_wa = {ls_q.addr[ADDR_W-1:PAGE_W], ss_q.idx};
      unique case (ss_q.st)
         eep_pkg::S_IDLE: begin
            if (stop_det && (sys_pins.sync_lvl[2] != ss_q.seq_done)) begin // R9
               ss_d.st = eep_pkg::S_COPY;
               ss_d.idx = '0;
               ss_d.seq_done = sys_pins.sync_lvl[2];
            end
         end
         eep_pkg::S_COPY: begin
            mem_we = ls_q.pval[ss_q.idx];
            ss_d.idx = ss_q.idx + 1'b1;
            if (ss_q.idx == PAGE_W'(PAGE_BYTES - 1)) begin
               ss_d.st = eep_pkg::S_WAIT;
               ss_d.wcnt = '0;
            end
         end
         eep_pkg::S_WAIT: begin
            ss_d.wcnt = ss_q.wcnt + 32'h1;
            if (ss_q.wcnt == 32'(WR_CYCLES - 1)) begin
               ss_d.st = eep_pkg::S_IDLE; // R10
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         ss_q <= '{st: eep_pkg::S_IDLE, idx: '0, wcnt: '0, seq_done: 1'b0,
                   scl_p: 1'b1, sda_p: 1'b1};
      end else begin
         ss_q <= ss_d;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (mem_we) begin
         mem[mem_wa] <= ls_q.pbuf[ss_q.idx];
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe_out = ls_q.drive;
   assign write_busy_out = ss_q.st != eep_pkg::S_IDLE;

   a_start_resets: assert property ( // R1
      @(negedge scl_in) disable iff (rst_in)
      start_seen |=> ls_q.st == eep_pkg::L_DEV && ls_q.cnt == 4'h0 && !ls_q.drive)
      else $error("start did not restart address phase");

   a_ack_on_match: assert property ( // R6
      @(negedge scl_in) disable iff (rst_in)
      (!start_seen && ls_q.st == eep_pkg::L_DEV && ls_q.cnt == 4'h7 && dev_match && !busy_l)
      |=> ls_q.drive ##1 !ls_q.drive || ls_q.st == eep_pkg::L_RDATA)
      else $error("matching address not acknowledged for one clock");

   a_no_ack_miss: assert property ( // R4
      @(negedge scl_in) disable iff (rst_in)
      (!start_seen && ls_q.st == eep_pkg::L_DEV && ls_q.cnt == 4'h7 && !dev_match)
      |=> !ls_q.drive && ls_q.st == eep_pkg::L_IDLE)
      else $error("mismatching address acknowledged");

   a_busy_refuse: assert property ( // R10
      @(negedge scl_in) disable iff (rst_in)
      (!start_seen && ls_q.st == eep_pkg::L_DEV && ls_q.cnt == 4'h7 && busy_l)
      |=> !ls_q.drive)
      else $error("acknowledged during write cycle");

   a_ack_ninth: assert property ( // R22
      @(negedge scl_in) disable iff (rst_in)
      (ls_q.drive && ls_q.st != eep_pkg::L_RDATA) |-> ls_q.cnt == 4'h8)
      else $error("acknowledge outside ninth clock");

   a_page_wrap: assert property ( // R12
      @(negedge scl_in) disable iff (rst_in)
      (!start_seen && ls_q.st == eep_pkg::L_WDATA && ls_q.cnt == 4'h7)
      |=> ls_q.addr[ADDR_W-1:PAGE_W] == $past(ls_q.addr[ADDR_W-1:PAGE_W])
          && ls_q.addr[PAGE_W-1:0] == PAGE_W'($past(ls_q.addr[PAGE_W-1:0]) + 1'b1))
      else $error("write address left its page");

   a_read_wrap: assert property ( // R16
      @(negedge scl_in) disable iff (rst_in)
      (!start_seen && ls_q.st == eep_pkg::L_RDATA && ls_q.cnt == 4'h7)
      |=> ls_q.addr == ADDR_W'($past(ls_q.addr) + 1'b1))
      else $error("read address did not advance");

   a_read_first: assert property ( // R17
      @(negedge scl_in) disable iff (rst_in)
      (!start_seen && ls_q.st == eep_pkg::L_DEV && ls_q.cnt == 4'h8 && ls_q.rw)
      |=> ls_q.st == eep_pkg::L_RDATA && ls_q.drive == !$past(rd_byte[7]))
      else $error("read data not started after address");

   a_nack_ends: assert property ( // R21
      @(negedge scl_in) disable iff (rst_in)
      (!start_seen && ls_q.st == eep_pkg::L_RDATA && ls_q.cnt == 4'h8 && rise_q)
      |=> ls_q.st == eep_pkg::L_IDLE && !ls_q.drive ##1 !ls_q.drive)
      else $error("read did not end on missing acknowledge");

   a_commit_busy: assert property ( // R9
      @(posedge clk_sys_in) disable iff (rst_in)
      (ss_q.st == eep_pkg::S_IDLE && stop_det && sys_pins.sync_lvl[2] != ss_q.seq_done)
      |=> write_busy_out [*8] ##COPY_TAIL ss_q.st == eep_pkg::S_WAIT)
      else $error("stop after write data did not start write cycle");
endmodule // eep_slave

// >>> test/eep_master.sv
// Two-wire bus master model driving the serial clock and its data pull-down
`timescale 1ns/1ns
module eep_master (
   input wire logic sda_in,
   output logic scl_out,
   output logic pull_out
);
   // Clock stands high between frames; data moves only while the clock is low, except at start and stop
   initial begin
      scl_out = 1'b1;
      pull_out = 1'b0;
   end
   task automatic start_bit();
      pull_out = 1'b0;
      #40 scl_out = 1'b1;
      #80 pull_out = 1'b1;
      #80 scl_out = 1'b0;
      #40;
   endtask
   task automatic stop_bit();
      pull_out = 1'b1;
      #40 scl_out = 1'b1;
      // Held low for several system clocks so the system-side detector sees it
      #200 pull_out = 1'b0;
      #200;
   endtask
   task automatic clk_bit(input logic b, output logic r);
      pull_out = ~b;
      #40 scl_out = 1'b1;
      #40 r = sda_in;
      #40 scl_out = 1'b0;
      #40;
   endtask
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], r);
      end
      clk_bit(1'b1, r);
      ack = ~r;
   endtask
   task automatic get_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, r);
         d[i] = r;
      end
      clk_bit(~ack, r);
   endtask
endmodule // eep_master

// >>> test/i2c_eeprom_slave_protocol_bench.sv
// Self-checking bench for the two-wire serial EEPROM slave
`timescale 1ns/1ns
module i2c_eeprom_slave_protocol_bench;
   localparam int WR_N = 50;
   logic clk_sys_in, rst_in, scl, pull, sda_in, sda_out, sda_oe_out, write_busy_out;
   logic [2:0] strap;
   int bad_count, n_tests, cyc, ptr;
   logic [7:0] mem [int];
   // Pull-up resistor: the line is low only while some party pulls it
   assign sda_in = ~pull & (sda_oe_out ? sda_out : 1'b1);
   eep_master bus (.sda_in(sda_in), .scl_out(scl), .pull_out(pull));
   eep_slave #(.WR_CYCLES(WR_N)) uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .scl_in(scl), .sda_in(sda_in), .chip_select_bit_2_in(strap[2]),
      .chip_select_bit_1_in(strap[1]), .chip_select_bit_0_in(strap[0]),
      .sda_out(sda_out), .sda_oe_out(sda_oe_out), .write_busy_out(write_busy_out));
   initial begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         $display("[FAIL] %0t run did not finish in time", $time);
         wrap_up();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic dev(input logic [3:0] kind, input logic [2:0] cs, input logic rd,
      input logic exp);
      logic a;
      bus.start_bit();
      bus.send_byte({kind, cs, rd}, a);
      chk({7'h0, a}, {7'h0, exp}, "address ack");
   endtask
   task automatic seek(input logic [12:0] adr);
      logic a;
      dev(4'ha, strap, 1'b0, 1'b1);
      // Upper three bits are junk and must be ignored
      bus.send_byte({3'b111, adr[12:8]}, a);
      chk({7'h0, a}, 8'h01, "word high ack");
      bus.send_byte(adr[7:0], a);
      chk({7'h0, a}, 8'h01, "word low ack");
      ptr = int'(adr);
   endtask
   task automatic wr(input logic [12:0] adr, input int n);
      logic a;
      logic [7:0] d;
      seek(adr);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         mem[int'({adr[12:5], 5'(adr[4:0] + 5'(i))})] = d;
         bus.send_byte(d, a);
         chk({7'h0, a}, 8'h01, "data ack");
      end
      ptr = int'({adr[12:5], 5'(adr[4:0] + 5'(n))});
      bus.stop_bit();
   endtask
   task automatic commit(input logic rd_poll);
      int k;
      logic [7:0] d;
      k = 0;
      while (write_busy_out !== 1'b1 && k < 10) begin
         @(negedge clk_sys_in);
         k++;
      end
      chk({7'h0, write_busy_out}, 8'h01, "write cycle started");
      dev(4'ha, strap, 1'b0, 1'b0);
      bus.stop_bit();
      k = 0;
      while (write_busy_out !== 1'b0 && k < 300) begin
         @(negedge clk_sys_in);
         k++;
      end
      chk({7'h0, k <= 32 + WR_N + 10}, 8'h01, "write cycle length");
      // Read poll only where the counter points at written bytes; the array is unset elsewhere
      dev(4'ha, strap, rd_poll, 1'b1);
      if (rd_poll) begin
         bus.get_byte(1'b0, d);
         chk(d, mem[ptr], "poll read data");
         ptr = (ptr + 1) % 8192;
      end
      bus.stop_bit();
   endtask
   task automatic rd(input int n);
      logic [7:0] d;
      dev(4'ha, strap, 1'b1, 1'b1);
      for (int i = 0; i < n; i++) begin
         bus.get_byte(i < n - 1, d);
         chk(d, mem[ptr], "read data");
         ptr = (ptr + 1) % 8192;
      end
      bus.stop_bit();
      chk({7'h0, sda_oe_out}, 8'h00, "line released");
   endtask
   initial begin
      bad_count = 0;
      n_tests = 0;
      cyc = 0;
      rst_in = 1'b1;
      void'($urandom(21235));
      strap = 3'($urandom);
      repeat (12) @(negedge clk_sys_in);
      rst_in = 1'b0;
      for (int k = 0; k < 16; k++) begin
         dev(4'(k), strap, 1'b0, k == 10);
         bus.stop_bit();
      end
      for (int c = 0; c < 8; c++) begin
         dev(4'ha, 3'(c), 1'b0, 3'(c) == strap);
         bus.stop_bit();
      end
      $display("test addressing done");
      @(negedge clk_sys_in);
      strap = 3'($urandom);
      wr(13'h0000, 1);
      commit(1'b0);
      $display("test byte write done");
      wr(13'h1ffe, 34);
      ptr = 13'h1fe0;
      commit(1'b1);
      $display("test page write done");
      rd(3);
      $display("test current read done");
      seek(13'h1ffe);
      rd(3);
      $display("test random read done");
      wrap_up();
   end
endmodule // i2c_eeprom_slave_protocol_bench
